// [pbs_ctrl.sv]
// Controller end: APB-programmed master of the SRAM bus
`timescale 1ns/1ps
module pbs_ctrl
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Strap
  input  wire logic        linear_order,
  // SRAM bus
  pbs_bus_if.ctl           bus
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_WR2   = 3'b010,
    S_BEAT  = 3'b011,
    S_NOP   = 3'b100,
    S_DESEL = 3'b101
  } pbs_ctl_state_type;

  typedef struct packed {
    pbs_ctl_state_type st;
    logic [15:0]       addr;
    logic [35:0]       wdata;
    logic [35:0]       rdata;
    logic              wr;
    logic              ctlstb;
    logic              glob;
    logic [3:0]        lanes;
    logic [1:0]        left;
    logic [31:0]       prdata;
    logic              err;
  } pbs_ctl_type;

  pbs_ctl_type r_r;
  pbs_ctl_type r_nxt;
  logic        wr_cyc;
  logic        acc;
  logic        busy;

  assign busy   = (r_r.st != S_IDLE);
  assign acc    = psel && penable;
  assign wr_cyc = r_r.wr && (r_r.st == S_WR2 || r_r.st == S_BEAT
                  || (r_r.st == S_ADDR && r_r.ctlstb));

  always_comb begin
    r_nxt = r_r;
    // Register read data latched in the setup cycle
    if (psel && !penable) begin
      r_nxt.err = 1'b0;
      case (paddr)
        OFS_ADDR: r_nxt.prdata = {16'h0000, r_r.addr};
        OFS_WDLO: r_nxt.prdata = r_r.wdata[31:0];
        OFS_WDHI: r_nxt.prdata = {28'h000_0000, r_r.wdata[35:32]};
        OFS_CMD:  r_nxt.prdata = {22'h00_0000, r_r.left, r_r.lanes, r_r.glob,
                                  r_r.ctlstb, r_r.wr, 1'b0};
        OFS_STAT: r_nxt.prdata = {31'h0000_0000, busy};
        OFS_RDLO: r_nxt.prdata = r_r.rdata[31:0];
        OFS_RDHI: r_nxt.prdata = {28'h000_0000, r_r.rdata[35:32]};
        default: begin
          r_nxt.prdata = RST_WORD;
          r_nxt.err    = 1'b1;
        end
      endcase
    end
    if (acc && pwrite && !busy) begin
      case (paddr)
        OFS_ADDR: r_nxt.addr = pwdata[15:0];
        OFS_WDLO: r_nxt.wdata[31:0] = pwdata;
        OFS_WDHI: r_nxt.wdata[35:32] = pwdata[3:0];
        OFS_CMD: begin
          r_nxt.wr     = pwdata[CMD_WR];
          r_nxt.ctlstb = pwdata[CMD_CTLSTB];
          r_nxt.glob   = pwdata[CMD_GLOB];
          r_nxt.lanes  = pwdata[CMD_LANE_L +: 4];
          r_nxt.left   = pwdata[CMD_BEAT_L +: 2];
          if (pwdata[CMD_GO]) begin
            r_nxt.st = S_ADDR;
          end
        end
        default: ;
      endcase
    end
    case (r_r.st)
      S_IDLE: ;
      S_ADDR: begin
        if (r_r.wr && !r_r.ctlstb) begin
          r_nxt.st = S_WR2;
        end else if (r_r.left != 2'h0) begin
          r_nxt.st = S_BEAT;
        end else begin
          r_nxt.st = S_NOP;
        end
      end
      S_WR2:   r_nxt.st = (r_r.left != 2'h0) ? S_BEAT : S_NOP;
      S_BEAT: begin
        r_nxt.left = 2'(r_r.left - ONE2);
        if (r_r.left == ONE2) begin
          r_nxt.st = S_NOP;
        end
      end
      S_NOP:   r_nxt.st = S_DESEL;
      S_DESEL: begin
        if (!r_r.wr) begin
          r_nxt.rdata = bus.dq;
        end
        r_nxt.st = S_IDLE;
      end
      default: r_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // APB answers without wait states
  assign pready  = 1'b1;
  assign pslverr = r_r.err;
  assign prdata  = r_r.prdata;

  // Bus drive decoded from the state
  assign bus.addr                     = r_r.addr;
  assign bus.processor_addr_strobe_n  = !(r_r.st == S_ADDR && !r_r.ctlstb);
  assign bus.controller_addr_strobe_n = !((r_r.st == S_ADDR && r_r.ctlstb)
                                          || r_r.st == S_DESEL);
  assign bus.burst_advance_n          = (r_r.st != S_BEAT);
  assign bus.global_write_n           = !(wr_cyc && r_r.glob);
  assign bus.byte_write_enable_n      = !(wr_cyc && !r_r.glob);
  assign bus.byte_lane_select_n       = wr_cyc ? ~r_r.lanes : ALL_LANES;
  assign bus.primary_select_n         = !(r_r.st == S_ADDR);
  assign bus.expansion_select_high    = 1'b1;
  assign bus.expansion_select_low_n   = 1'b0;
  // Output enable held high for the whole write
  assign bus.out_enable_n             = r_r.wr || !busy; // [R12]
  assign bus.burst_mode               = !linear_order;
  assign bus.dq_m_o                   = r_r.wdata;
  assign bus.dq_m_oe                  = wr_cyc;

endmodule : pbs_ctrl

// [pbs_pkg.sv]
// Shared constants for the pipelined burst SRAM ends
package pbs_pkg;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 36;
  localparam int unsigned LANES     = 4;
  localparam int unsigned LANE_W    = 9;
  localparam int unsigned DEPTH     = 65536;
  // Host register byte offsets
  localparam logic [7:0]  OFS_ADDR   = 8'h00;
  localparam logic [7:0]  OFS_WDLO   = 8'h04;
  localparam logic [7:0]  OFS_WDHI   = 8'h08;
  localparam logic [7:0]  OFS_CMD    = 8'h0C;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [7:0]  OFS_RDLO   = 8'h14;
  localparam logic [7:0]  OFS_RDHI   = 8'h18;
  // Command field positions
  localparam int unsigned CMD_GO     = 0;
  localparam int unsigned CMD_WR     = 1;
  localparam int unsigned CMD_CTLSTB = 2;
  localparam int unsigned CMD_GLOB   = 3;
  localparam int unsigned CMD_LANE_L = 4;
  localparam int unsigned CMD_BEAT_L = 8;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  ONE2       = 2'h1;
  localparam logic [3:0]  ALL_LANES  = 4'hF;
endpackage : pbs_pkg

// [pbs_bus_if.sv]
// Synchronous SRAM bus between controller end and memory end
`timescale 1ns/1ps
interface pbs_bus_if;
  logic [15:0] addr;
  logic        processor_addr_strobe_n;
  logic        controller_addr_strobe_n;
  logic        burst_advance_n;
  logic        global_write_n;
  logic        byte_write_enable_n;
  logic [3:0]  byte_lane_select_n;
  logic        primary_select_n;
  logic        expansion_select_high;
  logic        expansion_select_low_n;
  logic        out_enable_n;
  logic        burst_mode;
  logic [35:0] dq_m_o;
  logic        dq_m_oe;
  logic [35:0] dq_s_o;
  logic        dq_s_oe;
  logic [35:0] dq;
  // Resolved data lines; memory drive wins, idle lines read zero
  assign dq = dq_s_oe ? dq_s_o : (dq_m_oe ? dq_m_o : 36'h0_0000_0000);
  modport mem (
    input  addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input  global_write_n, byte_write_enable_n, byte_lane_select_n,
    input  primary_select_n, expansion_select_high, expansion_select_low_n,
    input  out_enable_n, burst_mode, dq,
    output dq_s_o, dq_s_oe
  );
  modport ctl (
    output addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output global_write_n, byte_write_enable_n, byte_lane_select_n,
    output primary_select_n, expansion_select_high, expansion_select_low_n,
    output out_enable_n, burst_mode, dq_m_o, dq_m_oe,
    input  dq
  );
endinterface : pbs_bus_if

// [pbs_sram.sv]
// Memory end: pipelined burst SRAM array with access and burst logic
// Function
// R1: Inputs sampled, read data output registered, rising edge
// R2: Burst order taken from sampled mode input
// R3: Two-bit wrap counter loaded at burst start
// R4: Global write low writes all four lanes
// R5: Read start needs strobe, selects, writes high
// R6: Read data driven after next edge, one-cycle latency
// R7: Outputs off during first cycle after selection
// R8: Deselect three-states at once; back-to-back reads
// R9: Processor strobe cycle ignores writes and advance
// R10: Processor-strobe write completes on second edge
// R11: Byte writes alter only selected lanes
// R12: Master raises output enable before driving data
// R13: Write cycle forces data pins off
// R14: Controller-strobe write completes in one cycle
// R15: Controller strobe cycle ignores burst advance
// R16: Advance low steps counter, read and write
// R17: Interleaved order XORs start with step
// R18: Linear order increments start modulo four
// R19: Output enable gates read drive asynchronously
// R20: Advance high holds current burst address
`timescale 1ns/1ps
module pbs_sram
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // SRAM bus
  pbs_bus_if.mem    bus
);

  typedef struct packed {
    logic        sel;
    logic        rd_act;
    logic        wr;
    logic        drive;
    logic        mode;
    logic [15:0] base;
    logic [1:0]  cnt;
    logic [15:0] rd_idx;
    logic [35:0] dout;
  } pbs_mem_state_type;

  logic [35:0]       mem_r [0:DEPTH-1];
  pbs_mem_state_type st_r;
  pbs_mem_state_type st_nxt;
  logic [3:0]        we;
  logic [15:0]       widx;
  logic              ce_ok;
  logic              wr_any;
  logic [3:0]        lanes;

  // Burst address of a given step
  function automatic logic [15:0] burst_idx(input logic [15:0] b, input logic [1:0] k,
                                            input logic m);
    logic [1:0] lo;
    lo = m ? (b[1:0] ^ k) : 2'(b[1:0] + k); // [R17] [R18]
    return {b[15:2], lo};
  endfunction

  assign ce_ok  = !bus.primary_select_n && bus.expansion_select_high
                  && !bus.expansion_select_low_n;
  assign lanes  = !bus.global_write_n ? ALL_LANES                     // [R4]
                  : (!bus.byte_write_enable_n ? ~bus.byte_lane_select_n : 4'h0); // [R11]
  assign wr_any = |lanes;

  always_comb begin
    st_nxt = st_r;
    we     = 4'h0;
    widx   = st_r.base;
    // Output register loads the previous edge's read address
    if (st_r.rd_act) begin
      st_nxt.dout = mem_r[st_r.rd_idx]; // [R1] [R6]
    end
    if (!bus.processor_addr_strobe_n && !bus.primary_select_n) begin
      // Processor strobe: a read when all selects are active, else a deselect; write and advance ignored
      if (ce_ok) begin
        st_nxt.sel    = 1'b1;
        st_nxt.base   = bus.addr;     // [R3]
        st_nxt.cnt    = 2'h0;
        st_nxt.mode   = bus.burst_mode; // [R2]
        st_nxt.rd_act = 1'b1;         // [R5] [R9]
        st_nxt.rd_idx = bus.addr;
        st_nxt.wr     = 1'b0;
      end else begin
        st_nxt.sel    = 1'b0;
        st_nxt.rd_act = 1'b0;
        st_nxt.wr     = 1'b0;
      end
    end else if (!bus.controller_addr_strobe_n) begin
      // Controller strobe: advance ignored
      if (ce_ok) begin
        st_nxt.sel    = 1'b1;
        st_nxt.base   = bus.addr;     // [R3] [R15]
        st_nxt.cnt    = 2'h0;
        st_nxt.mode   = bus.burst_mode; // [R2]
        st_nxt.rd_idx = bus.addr;
        if (wr_any) begin
          we            = lanes;      // [R14]
          widx          = bus.addr;
          st_nxt.rd_act = 1'b0;
          st_nxt.wr     = 1'b1;
        end else begin
          st_nxt.rd_act = 1'b1;       // [R5]
          st_nxt.wr     = 1'b0;
        end
      end else begin
        st_nxt.sel    = 1'b0;
        st_nxt.rd_act = 1'b0;
        st_nxt.wr     = 1'b0;
      end
    end else if (st_r.sel) begin
      // Continue or suspend an open burst
      if (!bus.burst_advance_n) begin
        st_nxt.cnt = 2'(st_r.cnt + ONE2); // [R16]
      end
      // Advance high keeps the count and the location
      widx          = burst_idx(st_r.base, st_nxt.cnt, st_r.mode); // [R20]
      st_nxt.rd_idx = widx;
      if (wr_any) begin
        we            = lanes;        // [R10] [R11]
        st_nxt.rd_act = 1'b0;
        st_nxt.wr     = 1'b1;
      end else begin
        st_nxt.rd_act = 1'b1;         // [R8]
        st_nxt.wr     = 1'b0;
      end
    end else begin
      st_nxt.rd_act = 1'b0;
      st_nxt.wr     = 1'b0;
    end
    // Drive only data of a read started at the previous edge, while still selected
    st_nxt.drive = st_r.rd_act && st_nxt.sel && !st_nxt.wr; // [R7] [R8] [R13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Lane-wise array write from data sampled at the edge
  always_ff @(posedge pclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (we[i]) begin
        mem_r[widx][i*LANE_W +: LANE_W] <= bus.dq[i*LANE_W +: LANE_W]; // [R1] [R11]
      end
    end
  end

  assign bus.dq_s_o  = st_r.dout;
  // Output enable acts without the clock; masked on writes
  assign bus.dq_s_oe = st_r.drive && !st_r.wr && !bus.out_enable_n; // [R19] [R13]

endmodule : pbs_sram

// [pbs_assertions.sv]
// Checker for the SRAM bus between the controller and memory ends
`timescale 1ns/1ps
module pbs_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus controls
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic primary_select_n,
  input wire logic out_enable_n,
  // Data drive enables
  input wire logic dq_m_oe,
  input wire logic dq_s_oe
);
  logic wr, rd_go, desel, hold, pstb_n, cstb_n;
  assign pstb_n = processor_addr_strobe_n;
  assign cstb_n = controller_addr_strobe_n;
  assign wr = pstb_n && !(global_write_n && byte_write_enable_n);
  assign rd_go = !primary_select_n && (!pstb_n || (!cstb_n && !wr));
  assign desel = primary_select_n && !cstb_n;
  assign hold = pstb_n && cstb_n && !wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  oe_gate_a: assert property (out_enable_n |-> !dq_s_oe) else $error("drive while oe high");
  write_off_a: assert property (wr |=> !dq_s_oe) else $error("drive after write");
  desel_off_a: assert property (desel |=> !dq_s_oe) else $error("drive after deselect");
  first_cycle_a: assert property (rd_go && $past(primary_select_n) |=> !dq_s_oe)
    else $error("drive in first cycle");
  read_drive_a: assert property (rd_go ##1 hold |=> out_enable_n || dq_s_oe)
    else $error("read data not driven");
  no_clash_a: assert property (!(dq_s_oe && dq_m_oe)) else $error("both ends drive");
  master_oe_a: assert property (dq_m_oe |-> out_enable_n && $past(out_enable_n))
    else $error("master drives with oe low");
  second_edge_a: assert property (!pstb_n ##1 wr |-> burst_advance_n && dq_m_oe)
    else $error("second write cycle malformed");
  one_cycle_a: assert property (!cstb_n && wr && !primary_select_n |-> dq_m_oe)
    else $error("no data with strobe write");
  cv_read: cover property (rd_go ##1 hold ##1 dq_s_oe);
  cv_cwr: cover property (!cstb_n && wr);
  cv_pwr: cover property (!pstb_n ##1 wr);
endmodule // pbs_assertions

// [tb.sv]
// Testbench: APB-driven controller and memory ends against a word model
`timescale 1ns/1ps
module tb;
  import pbs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, linear_order, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [35:0] mem [int];
  int          failures, cmp_count, cyc;
  pbs_bus_if bus_if ();
  pbs_ctrl pbs_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linear_order(linear_order), .bus(bus_if));
  pbs_sram pbs_sram_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if));
  pbs_assertions pbs_assertions_inst (.pclk(pclk), .presetn(presetn),
    .processor_addr_strobe_n(bus_if.processor_addr_strobe_n),
    .controller_addr_strobe_n(bus_if.controller_addr_strobe_n),
    .burst_advance_n(bus_if.burst_advance_n), .global_write_n(bus_if.global_write_n),
    .byte_write_enable_n(bus_if.byte_write_enable_n),
    .primary_select_n(bus_if.primary_select_n), .out_enable_n(bus_if.out_enable_n),
    .dq_m_oe(bus_if.dq_m_oe), .dq_s_oe(bus_if.dq_s_oe));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] baddr(input logic [15:0] a, input logic [1:0] k);
    logic [1:0] s;
    s = linear_order ? a[1:0] + k : a[1:0] ^ k;
    return {a[15:2], s};
  endfunction
  // Issue one bus operation, wait for idle, and update the model on writes
  task automatic run(input logic [15:0] a, input logic [35:0] d, input logic [9:0] c);
    int i;
    apb(1'b1, OFS_ADDR, {16'h0000, a});
    apb(1'b1, OFS_WDLO, d[31:0]);
    apb(1'b1, OFS_WDHI, {28'h0000000, d[35:32]});
    apb(1'b1, OFS_CMD, {22'h000000, c});
    i = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      i++;
    end while (q[0] !== 1'b0 && i < 40);
    check({35'h0, q[0]}, 36'h0);
    for (int k = 0; k <= int'(c[9:8]) && c[1]; k++) begin
      for (int l = 0; l < 4; l++) begin
        if (c[3] || c[4+l]) mem[baddr(a, 2'(k))][9*l+:9] = d[9*l+:9];
      end
    end
  endtask
  initial begin
    logic [15:0] a;
    logic [35:0] d;
    logic [9:0]  c;
    logic [31:0] lo;
    {psel, penable, pwrite, presetn, linear_order} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    a = 16'($urandom(56));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h1C, 32'h0);
    check({35'h0, err}, 36'h1);
    check({4'h0, q}, 36'h0);
    for (int n = 0; n < 24; n++) begin
      linear_order <= n[0];
      a = 16'($urandom);
      d = {4'($urandom), 32'($urandom)};
      run(a, d, {2'h3, 4'h0, 1'b1, n[1], 2'h3});
      d = {4'($urandom), 32'($urandom)};
      c = {2'($urandom), 4'($urandom_range(15, 1)), 1'($urandom), 1'($urandom), 2'h3};
      run(a, d, c);
      c = {2'($urandom), 4'h0, 1'b0, 1'($urandom), 2'h1};
      a = {a[15:2], 2'($urandom)};
      run(a, d, c);
      apb(1'b0, OFS_RDLO, 32'h0);
      lo = q;
      apb(1'b0, OFS_RDHI, 32'h0);
      check({q[3:0], lo}, mem[baddr(a, c[9:8])]);
    end
    test_done();
  end
endmodule // tb
